// ===== verilog/tbpw_top.sv
// Top: APB register file, reset synchroniser, timer and comparator
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tbpw_top
    import tbpw_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic PWM_O
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] period_limit;
    logic [7:0] duty_high;
    logic [1:0] duty_low;
    logic enable;
    tbpw_prescale_type prescale;
    logic timer_sel;
    tbpw_config_type cfg;
    tbpw_base_type base;
    logic [7:0] period_timer;
    logic [9:0] duty_value_reg;
    logic [9:0] active_duty;
    logic pwm_level;
    logic access;
    logic write_en;
    logic hit;
    logic [31:0] next_rdata;

    assign access = PSEL_I && PENABLE_I;
    assign write_en = access && PWRITE_I;
    assign hit = (PADDR_I == ADDR_PERIOD_LIMIT) || (PADDR_I == ADDR_PERIOD_TIMER) ||
                 (PADDR_I == ADDR_DUTY_HIGH) || (PADDR_I == ADDR_DUTY_LOW) ||
                 (PADDR_I == ADDR_CONTROL) || (PADDR_I == ADDR_STATUS);

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            period_limit <= PERIOD_LIMIT_RESET;
        end else if (write_en && (PADDR_I == ADDR_PERIOD_LIMIT)) begin
            period_limit <= PWDATA_I[7:0];
        end
    end

    // Duty buffer: written any time, output untouched until rollover
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            duty_high <= 8'h00;
        end else if (write_en && (PADDR_I == ADDR_DUTY_HIGH)) begin
            duty_high <= PWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            duty_low <= 2'h0;
        end else if (write_en && (PADDR_I == ADDR_DUTY_LOW)) begin
            duty_low <= PWDATA_I[DUTY_LOW_MSB:DUTY_LOW_LSB];
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 1'b0;
            prescale <= PRESCALE_1;
            timer_sel <= 1'b0;
        end else if (write_en && (PADDR_I == ADDR_CONTROL)) begin
            enable <= PWDATA_I[CTRL_ENABLE_BIT];
            prescale <= tbpw_prescale_type'(PWDATA_I[CTRL_PRESCALE_MSB:CTRL_PRESCALE_LSB]);
            timer_sel <= PWDATA_I[CTRL_TIMER_SEL_BIT];
        end
    end

    assign duty_value_reg = {duty_high, duty_low};
    assign cfg.enable = enable;
    assign cfg.prescale = prescale;
    assign cfg.period_limit = period_limit;

    // ----------------------------------------------------------------
    // Timer and comparator
    // ----------------------------------------------------------------
    tbpw_timer u_timer (
        .clk_i(CLOCK_I),
        .rst_n_i(rst_n),
        .cfg_i(cfg),
        .base_o(base),
        .count_o(period_timer)
    );

    tbpw_compare u_compare (
        .clk_i(CLOCK_I),
        .rst_n_i(rst_n),
        .base_i(base),
        .duty_buffer_i(duty_value_reg),
        .pwm_o(pwm_level),
        .active_duty_o(active_duty)
    );

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            PWM_O <= 1'b0;
        end else begin
            PWM_O <= pwm_level;
        end
    end

    // ----------------------------------------------------------------
    // APB read and answer
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = READ_ZERO;
        if (PADDR_I == ADDR_PERIOD_LIMIT) begin
            next_rdata[7:0] = period_limit;
        end else if (PADDR_I == ADDR_PERIOD_TIMER) begin
            next_rdata[7:0] = period_timer;
        end else if (PADDR_I == ADDR_DUTY_HIGH) begin
            next_rdata[7:0] = duty_high;
        end else if (PADDR_I == ADDR_DUTY_LOW) begin
            next_rdata[DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_low;
        end else if (PADDR_I == ADDR_CONTROL) begin
            next_rdata[CTRL_ENABLE_BIT] = enable;
            next_rdata[CTRL_PRESCALE_MSB:CTRL_PRESCALE_LSB] = prescale;
            next_rdata[CTRL_TIMER_SEL_BIT] = timer_sel;
        end else if (PADDR_I == ADDR_STATUS) begin
            next_rdata[STAT_OUTPUT_BIT] = PWM_O;
            next_rdata[STAT_RUNNING_BIT] = base.running;
            next_rdata[STAT_ACTIVE_MSB:STAT_ACTIVE_LSB] = active_duty;
        end
    end

    // Zero wait states: ready rises in the access cycle
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= READ_ZERO;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !hit;
            PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? next_rdata : READ_ZERO;
        end
    end

endmodule : tbpw_top

// ===== verilog/tbpw_pkg.sv
// Package: register map, fields, reset values and enums of the PWM block
package tbpw_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_PERIOD_LIMIT = 12'h000;
    localparam logic [11:0] ADDR_PERIOD_TIMER = 12'h004;
    localparam logic [11:0] ADDR_DUTY_HIGH = 12'h008;
    localparam logic [11:0] ADDR_DUTY_LOW = 12'h00C;
    localparam logic [11:0] ADDR_CONTROL = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PRESCALE_LSB = 1;
    localparam int CTRL_PRESCALE_MSB = 2;
    localparam int CTRL_TIMER_SEL_BIT = 3;
    localparam int DUTY_LOW_LSB = 6;
    localparam int DUTY_LOW_MSB = 7;
    localparam int STAT_OUTPUT_BIT = 0;
    localparam int STAT_RUNNING_BIT = 1;
    localparam int STAT_ACTIVE_LSB = 8;
    localparam int STAT_ACTIVE_MSB = 17;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int TIMER_WIDTH = 8;
    localparam int DUTY_WIDTH = 10;
    localparam int PRESCALE_WIDTH = 6;
    localparam logic [7:0] PERIOD_LIMIT_RESET = 8'hFF;
    localparam logic [9:0] DUTY_RESET = 10'h000;
    localparam logic [1:0] OSC_PHASE_LAST = 2'h3;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Prescale select codes: 1:1, 1:4, 1:16, 1:64
    typedef enum logic [1:0] {
        PRESCALE_1 = 2'h0,
        PRESCALE_4 = 2'h1,
        PRESCALE_16 = 2'h2,
        PRESCALE_64 = 2'h3
    } tbpw_prescale_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b100
    } tbpw_state_type;

    // Timer tick bundle handed to the comparator
    typedef struct packed {
        logic tick;
        logic rollover;
        logic [9:0] time_base;
        logic running;
    } tbpw_base_type;

    // Configuration bundle from the register file
    typedef struct packed {
        logic enable;
        tbpw_prescale_type prescale;
        logic [7:0] period_limit;
    } tbpw_config_type;

endpackage : tbpw_pkg

// ===== verilog/tbpw_timer.sv
// Base timer: oscillator phase, prescaler, period counter and 10-bit time base
`timescale 1ns/1ps
module tbpw_timer
    import tbpw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire tbpw_config_type cfg_i,
    output tbpw_base_type base_o,
    output logic [7:0] count_o
);

    // ----------------------------------------------------------------
    // Oscillator phase and prescaler
    // ----------------------------------------------------------------
    logic [1:0] osc_phase;
    logic [PRESCALE_WIDTH-1:0] prescale_count;
    logic [7:0] period_timer;
    logic [PRESCALE_WIDTH-1:0] prescale_last;
    logic quarter_tick;
    logic timer_tick;
    logic [1:0] low_bits;

    assign quarter_tick = cfg_i.enable && (osc_phase == OSC_PHASE_LAST);

    always_comb begin
        case (cfg_i.prescale)
            PRESCALE_1: prescale_last = 6'h00;
            PRESCALE_4: prescale_last = 6'h03;
            PRESCALE_16: prescale_last = 6'h0F;
            default: prescale_last = 6'h3F;
        endcase
    end

    assign timer_tick = quarter_tick && (prescale_count == prescale_last);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_phase <= 2'h0;
        end else if (!cfg_i.enable) begin
            osc_phase <= 2'h0;
        end else begin
            osc_phase <= osc_phase + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescale_count <= 6'h00;
        end else if (!cfg_i.enable || timer_tick) begin
            prescale_count <= 6'h00;
        end else if (quarter_tick) begin
            prescale_count <= prescale_count + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // Period counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_timer <= 8'h00;
        end else if (!cfg_i.enable) begin
            period_timer <= 8'h00;
        end else if (timer_tick) begin
            if (period_timer == cfg_i.period_limit) begin
                period_timer <= 8'h00;
            end else begin
                period_timer <= period_timer + 8'h01;
            end
        end
    end

    // Two low bits: oscillator phase at 1:1, top prescaler bits otherwise
    always_comb begin
        case (cfg_i.prescale)
            PRESCALE_1: low_bits = osc_phase;
            PRESCALE_4: low_bits = prescale_count[1:0];
            PRESCALE_16: low_bits = prescale_count[3:2];
            default: low_bits = prescale_count[5:4];
        endcase
    end

    assign base_o.tick = cfg_i.enable && (osc_phase == 2'h0) && (prescale_count == 6'h00);
    assign base_o.rollover = timer_tick && (period_timer == cfg_i.period_limit);
    assign base_o.time_base = {period_timer, low_bits};
    assign base_o.running = cfg_i.enable;
    assign count_o = period_timer;

endmodule : tbpw_timer

// ===== verilog/tbpw_compare.sv
// Duty comparator: latches the buffered duty and shapes the output level
`timescale 1ns/1ps
module tbpw_compare
    import tbpw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire tbpw_base_type base_i,
    input wire logic [9:0] duty_buffer_i,
    output logic pwm_o,
    output logic [9:0] active_duty_o
);

    tbpw_state_type state;
    tbpw_state_type next_state;
    logic [9:0] next_duty;

    // New duty taken on rollover, seen from the next time base start
    assign next_duty = duty_buffer_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_duty_o <= DUTY_RESET;
        end else if (base_i.rollover) begin
            active_duty_o <= next_duty;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (base_i.rollover) begin
                    next_state = (next_duty == DUTY_RESET) ? ST_LOW : ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (base_i.rollover) begin
                    next_state = (next_duty == DUTY_RESET) ? ST_LOW : ST_HIGH;
                end else if (base_i.time_base >= active_duty_o) begin
                    next_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (base_i.rollover) begin
                    next_state = (next_duty == DUTY_RESET) ? ST_LOW : ST_HIGH;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!base_i.running) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_o <= 1'b0;
        end else begin
            // Rises one clock after period start, so high lasts exactly duty steps
            pwm_o <= base_i.running && (state == ST_HIGH) &&
                     (base_i.time_base < active_duty_o);
        end
    end

endmodule : tbpw_compare

// ===== sim/tbpw_assertions.sv
// Checker: APB handshake and PWM output properties seen at the top ports
`timescale 1ns/1ps
module tbpw_assertions
    import tbpw_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic PWM_O
);
    logic unm;
    assign unm = (PADDR_I > ADDR_STATUS) || (PADDR_I[1:0] != 2'h0);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    property p_ready; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_ready_acc; PREADY_O |-> PSEL_I && PENABLE_I; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
    property p_ready_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_rdata_idle; !PREADY_O |-> PRDATA_O == READ_ZERO; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_unm; PREADY_O && unm |-> PSLVERR_O && PRDATA_O == READ_ZERO; endproperty
    a_unm: assert property (p_unm) else $error("unmapped access accepted");
    property p_mapped; PREADY_O && !unm |-> !PSLVERR_O; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_err_ready; PSLVERR_O |-> PREADY_O; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rst_low; $rose(RESETN_I) |-> !PWM_O ##1 !PWM_O; endproperty
    a_rst_low: assert property (p_rst_low) else $error("output high after reset");
    property p_spacing; $rose(PWM_O) |=> !$rose(PWM_O) [*3]; endproperty
    a_spacing: assert property (p_spacing) else $error("period under four clocks");
endmodule : tbpw_assertions

bind tbpw_top tbpw_assertions u_chk (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PWM_O(PWM_O));

// ===== sim/tb_top.sv
// Testbench: register access and PWM timing scenarios
`timescale 1ns/1ps
module tb_top
    import tbpw_pkg::*;
;
    logic clk = 1'b0;
    logic rstn, psel, penable, pwrite, pready, pslverr, pwm, er_q;
    logic pwm_q = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    int n_fail, n_tests, cyc, n_rise, prev_rise, last_rise, last_fall;

    always #2.5 clk = ~clk;

    tbpw_top u_dut (.CLOCK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PWM_O(pwm));

    // ----------------------------------------------------------------
    // Output edge monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (pwm === 1'b1 && pwm_q === 1'b0) begin
            prev_rise = last_rise;
            last_rise = cyc;
            n_rise++;
        end
        if (pwm === 1'b0 && pwm_q === 1'b1) begin
            last_fall = cyc;
        end
        pwm_q = pwm;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", 32'h1, {31'h0, pready});
        rd_q = prdata;
        er_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd_q);
    endtask : rdc

    task automatic set_duty(input logic [9:0] d);
        apb(1'b1, ADDR_DUTY_HIGH, {24'h0, d[9:2]});
        apb(1'b1, ADDR_DUTY_LOW, {24'h0, d[1:0], 6'h0});
    endtask : set_duty

    task automatic wait_rises(input int k);
        int t;
        t = n_rise + k;
        for (int i = 0; i < 5000 && n_rise < t; i++) @(posedge clk);
        chk("rises", 32'(t), 32'(n_rise));
    endtask : wait_rises

    task automatic pulse(input string nm, input int hi, input int per);
        chk({nm, " high"}, 32'(hi), 32'(last_fall - prev_rise));
        chk({nm, " period"}, 32'(per), 32'(last_rise - prev_rise));
    endtask : pulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rdc("limit", ADDR_PERIOD_LIMIT, {24'h0, PERIOD_LIMIT_RESET});
        rdc("duty_high", ADDR_DUTY_HIGH, 32'h0);
        rdc("status", ADDR_STATUS, 32'h0);
        chk("pwm", 32'h0, {31'h0, pwm});
        rdc("control", ADDR_CONTROL, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h8);
        rdc("control", ADDR_CONTROL, 32'h8);
        apb(1'b1, ADDR_DUTY_LOW, 32'hFF);
        rdc("duty_low", ADDR_DUTY_LOW, 32'hC0);
        apb(1'b1, 12'h018, 32'hFF);
        chk("wr slverr", 32'h1, {31'h0, er_q});
        rdc("unmapped", 12'h018, 32'h0);
        chk("rd slverr", 32'h1, {31'h0, er_q});
        $display("test regs done");
    endtask : t_regs

    task automatic t_prescale;
        apb(1'b1, ADDR_PERIOD_LIMIT, 32'h3);
        set_duty(10'h006);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CONTROL, 32'(i * 2 + 1));
            wait_rises(3);
            pulse("prescale", 6 << (2 * i), 16 << (2 * i));
        end
        $display("test prescale done");
    endtask : t_prescale

    task automatic t_buffer;
        apb(1'b1, ADDR_CONTROL, 32'h3);
        wait_rises(3);
        set_duty(10'h00A);
        wait_rises(1);
        pulse("held", 24, 64);
        wait_rises(1);
        pulse("new", 40, 64);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("active", 32'hA, {22'h0, rd_q[STAT_ACTIVE_MSB:STAT_ACTIVE_LSB]});
        $display("test buffer done");
    endtask : t_buffer

    task automatic t_zero;
        int r;
        set_duty(10'h000);
        repeat (70) @(posedge clk);
        r = n_rise;
        repeat (140) @(posedge clk);
        chk("zero rises", 32'(r), 32'(n_rise));
        chk("zero pwm", 32'h0, {31'h0, pwm});
        $display("test zero done");
    endtask : t_zero

    task automatic t_full;
        apb(1'b1, ADDR_PERIOD_LIMIT, 32'hFF);
        apb(1'b1, ADDR_CONTROL, 32'h1);
        set_duty(10'h3FF);
        wait_rises(3);
        pulse("full", 1023, 1024);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        repeat (4) @(posedge clk);
        chk("off pwm", 32'h0, {31'h0, pwm});
        rdc("off timer", ADDR_PERIOD_TIMER, 32'h0);
        $display("test full done");
    endtask : t_full

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs;
        t_prescale;
        t_buffer;
        t_zero;
        t_full;
        give_verdict;
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
endmodule : tb_top
